/* File: bench/mhpa_host_model.sv */
`default_nettype none

module mhpa_host_model (
	input  wire logic                        core_clk,
	input  wire logic                        host_ready_out,
	input  wire logic [mhpa_pkg::WORD_W-1:0] host_data_bus_out,
	output logic                             host_chip_select_n,
	output logic      [1:0]                  host_data_strobes_n,
	output logic                             host_address_strobe_n,
	output logic      [1:0]                  register_select,
	output logic                             host_read_write,
	output logic                             halfword_identifier,
	output logic      [mhpa_pkg::BE_W-1:0]   host_byte_enables_n,
	output logic      [mhpa_pkg::WORD_W-1:0] host_data_bus_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle host: nothing selected, no strobe
	initial begin
		host_chip_select_n = 1'b1;
		host_data_strobes_n = 2'b11;
		host_address_strobe_n = 1'b1;
		register_select = 2'h0;
		host_read_write = 1'b1;
		halfword_identifier = 1'b0;
		host_byte_enables_n = 4'hf;
		host_data_bus_in = 32'h0;
	end

	// One access; pre and post report ready low before and after the strobe rise
	task automatic access(input logic rd, input logic [1:0] sel, input logic hw,
		input logic [3:0] be_n, input logic [31:0] wdata, input logic has,
		output logic pre, output logic post, output logic [31:0] rdata);
		int n;
		pre = 1'b0;
		@(posedge core_clk) #1;
		host_chip_select_n = 1'b0;
		register_select = sel;
		host_read_write = rd;
		halfword_identifier = hw;
		host_byte_enables_n = be_n;
		host_data_bus_in = wdata;
		if (has) begin
			repeat (6) @(posedge core_clk) #1;
			host_address_strobe_n = 1'b0;
			repeat (6) @(posedge core_clk) #1;
			register_select = ~sel; // Stale after capture, must not matter
			host_read_write = ~rd;
		end
		repeat (6) @(posedge core_clk) #1;
		host_data_strobes_n = 2'b10;
		for (n = 0; n < 10; n++) begin
			@(posedge core_clk) #1;
			if (!host_ready_out) pre = 1'b1;
		end
		// Strobe is held until the port says ready
		for (n = 0; n < 400 && !host_ready_out; n++) @(posedge core_clk) #1;
		host_address_strobe_n = 1'b1;
		repeat (4) @(posedge core_clk) #1;
		rdata = host_data_bus_out;
		host_data_strobes_n = 2'b11;
		repeat (12) @(posedge core_clk) #1;
		post = !host_ready_out;
		host_chip_select_n = 1'b1;
		host_data_bus_in = ~wdata; // No stale value left on the bus
		repeat (10) @(posedge core_clk) #1;
	endtask : access

	// Strobe pulses with chip select inactive
	task automatic stray();
		// Write select, so an ungated strobe would queue an entry
		register_select = 2'h0;
		host_read_write = 1'b0;
		repeat (3) begin
			@(posedge core_clk) #1 host_data_strobes_n = 2'b10;
			repeat (8) @(posedge core_clk);
			#1 host_data_strobes_n = 2'b11;
			repeat (8) @(posedge core_clk);
		end
	endtask : stray

endmodule : mhpa_host_model

`default_nettype wire

/* File: bench/mhpa_port_test.sv */
`default_nettype none

module mhpa_port_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk, rst, host_chip_select_n, host_address_strobe_n;
	logic [1:0]  host_data_strobes_n, register_select, req_select;
	logic        host_read_write, halfword_identifier, host_data_bus_oe, host_ready_out;
	logic [3:0]  host_byte_enables_n, req_byte_enables;
	logic [31:0] host_data_bus_in, host_data_bus_out, req_data;
	logic        use_address_strobe, dual_halfword_mode, req_valid, req_ready, req_read;
	logic        write_fifo_full, write_fifo_empty, write_fifo_one_left, write_fifo_flush;
	logic        read_fifo_empty, read_fifo_one_left, read_fifo_flush, read_return_valid;
	logic [31:0] read_fifo_head, control_reg_value, address_reg_value, read_return_data;
	logic [38:0] popped[$];
	int          miscompares, compares, due;
	logic        take_now, fetch_now, oe_seen;

	mhpa_port mhpa_port_inst (
		.core_clk, .rst, .host_chip_select_n, .host_data_strobes_n, .host_address_strobe_n,
		.register_select, .host_read_write, .halfword_identifier, .host_byte_enables_n,
		.host_data_bus_in, .host_data_bus_out, .host_data_bus_oe, .host_ready_out,
		.use_address_strobe, .dual_halfword_mode, .write_fifo_full, .write_fifo_empty,
		.write_fifo_one_left, .write_fifo_flush, .read_fifo_empty, .read_fifo_one_left,
		.read_fifo_flush, .read_fifo_head, .control_reg_value, .address_reg_value,
		.read_return_valid, .read_return_data, .req_valid, .req_ready, .req_read,
		.req_select, .req_byte_enables, .req_data
	);

	mhpa_host_model mhpa_host_model_inst (
		.core_clk, .host_ready_out, .host_data_bus_out, .host_chip_select_n,
		.host_data_strobes_n, .host_address_strobe_n, .register_select, .host_read_write,
		.halfword_identifier, .host_byte_enables_n, .host_data_bus_in
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Core side: log every entry taken, answer a fetch four cycles later
	always @(posedge core_clk) begin
		take_now = req_valid && req_ready;
		if (host_data_bus_oe) oe_seen = 1'b1; // Any drive since the last clear
		fetch_now = take_now && req_read && req_select === mhpa_pkg::SEL_DATA_FIX;
		if (take_now) popped.push_back({req_read, req_select, req_byte_enables, req_data});
		#1;
		read_return_valid = (due == 1);
		due = fetch_now ? 4 : (due != 0 ? due - 1 : 0);
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		compares++;
		if (seen !== want) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// Oldest logged entry, waited for under a bound
	task automatic take(input logic [38:0] want);
		for (int n = 0; n < 60 && popped.size() == 0; n++) @(posedge core_clk);
		if (popped.size() == 0) check(64'h0, {25'h0, want});
		else check(popped.pop_front(), want);
	endtask : take

	// Write with write FIFO status st, changed to rel while the host waits
	task automatic wcase(input logic [1:0] sel, input logic [3:0] st, input logic [3:0] rel,
		input logic [3:0] be_n, input logic xp, input logic xq, input logic [31:0] d);
		logic pre, post;
		logic [31:0] rd;
		popped.delete();
		{write_fifo_full, write_fifo_empty, write_fifo_one_left, write_fifo_flush} = st;
		oe_seen = 1'b0;
		fork
			mhpa_host_model_inst.access(1'b0, sel, 1'b0, be_n, d, 1'b0, pre, post, rd);
			begin
				repeat (40) @(posedge core_clk);
				#1 {write_fifo_full, write_fifo_empty, write_fifo_one_left, write_fifo_flush} = rel;
			end
		join
		check(pre, xp);
		check(post, xq);
		check(oe_seen, 1'b0);
		check(host_ready_out, 1'b1);
		take({1'b0, sel, ~be_n, d});
	endtask : wcase

	// Read with read FIFO status st, changed to rel while the host waits
	task automatic rcase(input logic [1:0] sel, input logic hw, input logic [2:0] st,
		input logic [2:0] rel, input logic xp, input logic xq, input logic [31:0] want);
		logic pre, post;
		logic [31:0] rd;
		{read_fifo_empty, read_fifo_one_left, read_fifo_flush} = st;
		oe_seen = 1'b0;
		fork
			mhpa_host_model_inst.access(1'b1, sel, hw, 4'ha, 32'h0, 1'b0, pre, post, rd);
			begin
				repeat (40) @(posedge core_clk);
				#1 {read_fifo_empty, read_fifo_one_left, read_fifo_flush} = rel;
			end
		join
		check(pre, xp);
		check(post, xq);
		check(rd, want);
		check(oe_seen, 1'b1);
		check(host_ready_out, 1'b1);
	endtask : rcase

	task automatic t_writes();
		wcase(mhpa_pkg::SEL_CTRL, 4'h4, 4'h4, 4'h0, 1'b0, 1'b0, 32'h0000_0a01);
		wcase(mhpa_pkg::SEL_ADDR, 4'h4, 4'h4, 4'h0, 1'b0, 1'b0, 32'h8000_0000);
		wcase(mhpa_pkg::SEL_DATA_INC, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 32'h1111_2222);
		wcase(mhpa_pkg::SEL_DATA_INC, 4'h8, 4'h2, 4'h0, 1'b1, 1'b1, 32'h3333_4444);
		wcase(mhpa_pkg::SEL_DATA_INC, 4'h1, 4'h0, 4'h0, 1'b1, 1'b0, 32'h5555_6666);
		wcase(mhpa_pkg::SEL_DATA_INC, 4'h2, 4'h2, 4'h0, 1'b0, 1'b1, 32'h7777_8888);
		wcase(mhpa_pkg::SEL_DATA_FIX, 4'h0, 4'h4, 4'h9, 1'b1, 1'b1, 32'h9999_aaaa);
		wcase(mhpa_pkg::SEL_DATA_FIX, 4'h4, 4'h4, 4'h6, 1'b0, 1'b1, 32'hbbbb_cccc);
	endtask : t_writes

	task automatic t_reads();
		rcase(mhpa_pkg::SEL_CTRL, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0, control_reg_value);
		rcase(mhpa_pkg::SEL_ADDR, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0, address_reg_value);
		rcase(mhpa_pkg::SEL_DATA_INC, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0, read_fifo_head);
		rcase(mhpa_pkg::SEL_DATA_INC, 1'b0, 3'h2, 3'h2, 1'b0, 1'b1, read_fifo_head);
		rcase(mhpa_pkg::SEL_DATA_INC, 1'b0, 3'h4, 3'h2, 1'b1, 1'b1, read_fifo_head);
		rcase(mhpa_pkg::SEL_DATA_FIX, 1'b0, 3'h0, 3'h0, 1'b1, 1'b0, read_return_data);
	endtask : t_reads

	// Two entries with the core stalled fill the buffer; a repeated address write waits
	task automatic t_buffer();
		logic pre, post;
		logic [31:0] rd;
		popped.delete();
		req_ready = 1'b0;
		mhpa_host_model_inst.access(1'b0, 2'h2, 1'b0, 4'h0, 32'ha000_0000, 1'b0, pre, post, rd);
		check(pre, 1'b0);
		mhpa_host_model_inst.access(1'b0, 2'h0, 1'b0, 4'h0, 32'h0000_0c01, 1'b0, pre, post, rd);
		check(req_valid, 1'b1);
		fork
			mhpa_host_model_inst.access(1'b0, 2'h2, 1'b0, 4'h0, 32'hb000_0000, 1'b0, pre, post, rd);
			begin
				repeat (40) @(posedge core_clk);
				#1 req_ready = 1'b1;
			end
		join
		check(pre, 1'b1);
		take({1'b0, 2'h2, 4'hf, 32'ha000_0000});
		take({1'b0, 2'h0, 4'hf, 32'h0000_0c01});
		take({1'b0, 2'h2, 4'hf, 32'hb000_0000});
	endtask : t_buffer

	// Dual halfword: fixed write stalls only on the second half, then both reads
	task automatic t_dual();
		logic pre, post;
		logic [31:0] rd;
		popped.delete();
		dual_halfword_mode = 1'b1;
		{write_fifo_full, write_fifo_empty, write_fifo_one_left, write_fifo_flush} = 4'h0;
		mhpa_host_model_inst.access(1'b0, 2'h3, 1'b0, 4'h1, 32'h0000_1357, 1'b0, pre, post, rd);
		check(pre, 1'b0);
		fork
			mhpa_host_model_inst.access(1'b0, 2'h3, 1'b1, 4'h0, 32'h0000_2468, 1'b0, pre, post, rd);
			begin
				repeat (40) @(posedge core_clk);
				#1 write_fifo_empty = 1'b1;
			end
		join
		check(pre, 1'b1);
		take({1'b0, 2'h3, 4'he, 32'h2468_1357});
		rcase(mhpa_pkg::SEL_CTRL, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0, 32'h0000_0001);
		rcase(mhpa_pkg::SEL_CTRL, 1'b1, 3'h0, 3'h0, 1'b0, 1'b0, 32'h0000_c0de);
		dual_halfword_mode = 1'b0;
	endtask : t_dual

	// Select taken at the address strobe, then stray strobes without chip select
	task automatic t_strobes();
		logic pre, post;
		logic [31:0] rd;
		popped.delete();
		use_address_strobe = 1'b1;
		mhpa_host_model_inst.access(1'b0, 2'h0, 1'b0, 4'h0, 32'h0000_0e01, 1'b1, pre, post, rd);
		take({1'b0, 2'h0, 4'hf, 32'h0000_0e01});
		use_address_strobe = 1'b0;
		mhpa_host_model_inst.stray();
		check(popped.size(), 0);
		check(host_ready_out, 1'b1);
	endtask : t_strobes

	task automatic end_of_test();
		if (miscompares == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// Whole run needs well under two thousand cycles; this bound only cuts a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		{use_address_strobe, dual_halfword_mode, req_ready, read_return_valid} = 4'h2;
		{write_fifo_full, write_fifo_empty, write_fifo_one_left, write_fifo_flush} = 4'h4;
		{read_fifo_empty, read_fifo_one_left, read_fifo_flush} = 3'h0;
		read_fifo_head = 32'h600d_0002;
		control_reg_value = 32'hc0de_0001;
		address_reg_value = 32'h8000_0040;
		read_return_data = 32'hfeed_0003;
		repeat (6) @(posedge core_clk);
		#1 rst = 1'b0;
		t_writes();
		t_reads();
		t_buffer();
		t_dual();
		t_strobes();
		end_of_test();
	end

endmodule : mhpa_port_test

`default_nettype wire

/* File: hdl/mhpa_port.sv */
`default_nettype none

module mhpa_port #(
	parameter int BUF_DEPTH = mhpa_pkg::BUF_DEPTH
) (
	input  wire logic                            core_clk,
	input  wire logic                            rst,
	input  wire logic                            host_chip_select_n,
	input  wire logic [1:0]                      host_data_strobes_n,
	input  wire logic                            host_address_strobe_n,
	input  wire logic [1:0]                      register_select,
	input  wire logic                            host_read_write,
	input  wire logic                            halfword_identifier,
	input  wire logic [mhpa_pkg::BE_W-1:0]       host_byte_enables_n,
	input  wire logic [mhpa_pkg::WORD_W-1:0]     host_data_bus_in,
	output logic      [mhpa_pkg::WORD_W-1:0]     host_data_bus_out,
	output logic                                 host_data_bus_oe,
	output logic                                 host_ready_out,
	input  wire logic                            use_address_strobe,
	input  wire logic                            dual_halfword_mode,
	input  wire logic                            write_fifo_full,
	input  wire logic                            write_fifo_empty,
	input  wire logic                            write_fifo_one_left,
	input  wire logic                            write_fifo_flush,
	input  wire logic                            read_fifo_empty,
	input  wire logic                            read_fifo_one_left,
	input  wire logic                            read_fifo_flush,
	input  wire logic [mhpa_pkg::WORD_W-1:0]     read_fifo_head,
	input  wire logic [mhpa_pkg::WORD_W-1:0]     control_reg_value,
	input  wire logic [mhpa_pkg::WORD_W-1:0]     address_reg_value,
	input  wire logic                            read_return_valid,
	input  wire logic [mhpa_pkg::WORD_W-1:0]     read_return_data,
	output logic                                 req_valid,
	input  wire logic                            req_ready,
	output logic                                 req_read,
	output logic      [1:0]                      req_select,
	output logic      [mhpa_pkg::BE_W-1:0]       req_byte_enables,
	output logic      [mhpa_pkg::WORD_W-1:0]     req_data
);

	localparam int EW = 1 + 2 + mhpa_pkg::BE_W + mhpa_pkg::WORD_W;
	localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int CW = $clog2(BUF_DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(BUF_DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(BUF_DEPTH);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Three-stage pin synchroniser; a change counts once stages two and three agree
	logic [mhpa_pkg::SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	logic                        p_cs_n, p_as_n, p_rw, p_hw;
	logic [1:0]                  p_ds_n, p_sel;
	logic [mhpa_pkg::BE_W-1:0]   p_be_n;
	logic [mhpa_pkg::WORD_W-1:0] p_data;
	always_comb begin
		filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_reg   <= mhpa_pkg::PIN_IDLE;
			s2_reg   <= mhpa_pkg::PIN_IDLE;
			s3_reg   <= mhpa_pkg::PIN_IDLE;
			filt_reg <= mhpa_pkg::PIN_IDLE;
		end else begin
			s1_reg   <= {host_chip_select_n, host_data_strobes_n, host_address_strobe_n,
				register_select, host_read_write, halfword_identifier,
				host_byte_enables_n, host_data_bus_in};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	assign {p_cs_n, p_ds_n, p_as_n, p_sel, p_rw, p_hw, p_be_n, p_data} = filt_reg;

	// Internal strobe exists only under chip select
	logic cs_act, strb, strb_d_reg, as_act, as_d_reg;
	logic strb_fall, strb_rise, as_fall;
	assign cs_act    = ~p_cs_n;
	assign strb      = cs_act & (p_ds_n[0] ^ p_ds_n[1]); // [R23]
	assign as_act    = ~p_as_n;
	assign strb_fall = strb & ~strb_d_reg;
	assign strb_rise = ~strb & strb_d_reg;
	assign as_fall   = as_act & ~as_d_reg;
	// Select, direction and halfword caught on the address strobe fall
	logic [1:0] as_sel_reg, as_sel_next, cur_sel;
	logic       as_rw_reg, as_rw_next, as_hw_reg, as_hw_next, cur_rd, cur_hw;
	always_comb begin
		as_sel_next = as_sel_reg;
		as_rw_next  = as_rw_reg;
		as_hw_next  = as_hw_reg;
		if (as_fall) begin
			as_sel_next = p_sel; // [R03]
			as_rw_next  = p_rw;
			as_hw_next  = p_hw; // [R07]
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			strb_d_reg <= 1'b0;
			as_d_reg   <= 1'b0;
			as_sel_reg <= mhpa_pkg::SEL_CTRL;
			as_rw_reg  <= 1'b1;
			as_hw_reg  <= 1'b0;
		end else begin
			strb_d_reg <= strb;
			as_d_reg   <= as_act;
			as_sel_reg <= as_sel_next;
			as_rw_reg  <= as_rw_next;
			as_hw_reg  <= as_hw_next;
		end
	end

	// Without the address strobe the strobe fall takes the live pins
	assign cur_sel = use_address_strobe ? as_sel_reg : p_sel; // [R02] [R03] [R01]
	assign cur_rd  = use_address_strobe ? as_rw_reg : p_rw;
	assign cur_hw  = use_address_strobe ? as_hw_reg : p_hw; // [R07]
	// Two-entry request buffer toward the core
	logic [EW-1:0]  mem_reg [BUF_DEPTH];
	logic [EW-1:0]  mem_next [BUF_DEPTH];
	logic [PW-1:0]  wp_reg, wp_next, rp_reg, rp_next;
	logic [CW-1:0]  cnt_reg, cnt_next;
	logic           in_ready, push, pop;
	logic [EW-1:0]  push_entry;
	assign in_ready  = (cnt_reg != CNT_FULL);
	assign pop       = req_valid & req_ready;
	assign req_valid = (cnt_reg != '0);
	assign {req_read, req_select, req_byte_enables, req_data} = mem_reg[rp_reg];
	always_comb begin
		mem_next = mem_reg;
		wp_next  = wp_reg;
		rp_next  = rp_reg;
		cnt_next = cnt_reg;
		if (push) begin
			mem_next[wp_reg] = push_entry;
			wp_next = (wp_reg == PTR_LAST) ? '0 : wp_reg + 1'b1;
		end
		if (pop)
			rp_next = (rp_reg == PTR_LAST) ? '0 : rp_reg + 1'b1;
		if (push && !pop)
			cnt_next = cnt_reg + 1'b1;
		else if (pop && !push)
			cnt_next = cnt_reg - 1'b1;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < BUF_DEPTH; i++)
				mem_reg[i] <= '0;
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end
	// Address write not yet taken by the core; read by the stall test
	logic addr_pend_reg, addr_pend_next;
	// Stall test; the fixed-read term applies only at the start of the access
	function automatic logic pre_stall(input logic [1:0] s, input logic rd,
			input logic start);
		logic data_sel;
		data_sel = (s == mhpa_pkg::SEL_DATA_INC) || (s == mhpa_pkg::SEL_DATA_FIX);
		if (rd)
			pre_stall = (start && s == mhpa_pkg::SEL_DATA_FIX)
				|| (s == mhpa_pkg::SEL_DATA_INC && (read_fifo_empty || read_fifo_flush))
				|| (data_sel && !in_ready); // [R21]
		else
			pre_stall = (s == mhpa_pkg::SEL_ADDR && addr_pend_reg)
				|| (s == mhpa_pkg::SEL_DATA_INC && (write_fifo_full || write_fifo_flush))
				|| (s == mhpa_pkg::SEL_DATA_FIX && (!write_fifo_empty || write_fifo_flush))
				|| !in_ready; // [R15] [R16] [R17]
	endfunction : pre_stall
	// Access sequencer
	mhpa_pkg::mhpa_state_t st_reg, st_next;
	logic [1:0]                   acc_sel_reg, acc_sel_next, rsel;
	logic                         acc_rd_reg, acc_rd_next, acc_hw_reg, acc_hw_next;
	logic [mhpa_pkg::HALF_W-1:0]  lo_data_reg, lo_data_next;
	logic [1:0]                   lo_be_reg, lo_be_next;
	logic [mhpa_pkg::WORD_W-1:0]  rdata_reg, rdata_next, out_reg, out_next;
	logic                         post_rd_reg, post_rd_next;
	logic                         first_cur, last_cur, last_acc, do_read, addr_set, addr_drain;
	logic                         wr_post;
	logic [mhpa_pkg::BE_W-1:0]    be_full;
	logic [mhpa_pkg::WORD_W-1:0]  data_full;
	assign first_cur = !dual_halfword_mode || !cur_hw;
	assign last_cur  = !dual_halfword_mode || cur_hw;
	assign last_acc  = !dual_halfword_mode || acc_hw_reg;
	assign rsel      = (st_reg == mhpa_pkg::ST_IDLE) ? cur_sel : acc_sel_reg;
	assign addr_drain = pop && !req_read && req_select == mhpa_pkg::SEL_ADDR;
	// Second halfword supplies the upper enables; the first pair was held
	assign be_full   = dual_halfword_mode ? {~p_be_n[1:0], lo_be_reg} : ~p_be_n; // [R06]
	assign data_full = dual_halfword_mode ? {p_data[mhpa_pkg::HALF_W-1:0], lo_data_reg}
		: p_data; // [R04]
	assign wr_post   = (acc_sel_reg == mhpa_pkg::SEL_DATA_FIX)
		|| (acc_sel_reg == mhpa_pkg::SEL_DATA_INC
		&& (write_fifo_one_left || write_fifo_full)); // [R16] [R17] [R18] [R19]
	always_comb begin
		st_next      = st_reg;
		acc_sel_next = acc_sel_reg;
		acc_rd_next  = acc_rd_reg;
		acc_hw_next  = acc_hw_reg;
		lo_data_next = lo_data_reg;
		lo_be_next   = lo_be_reg;
		rdata_next   = rdata_reg;
		post_rd_next = post_rd_reg;
		do_read      = 1'b0;
		addr_set     = 1'b0;
		push         = 1'b0;
		// Reads carry no enables, whatever the pins show
		push_entry   = {1'b1, rsel, mhpa_pkg::BE_NONE, mhpa_pkg::WORD_ZERO}; // [R11]
		case (st_reg)
			mhpa_pkg::ST_IDLE: begin
				if (strb_fall) begin
					acc_sel_next = cur_sel; // [R02] [R07]
					acc_rd_next  = cur_rd;
					acc_hw_next  = cur_hw;
					// Dual writes check only on the second halfword
					if (cur_rd ? (first_cur && pre_stall(cur_sel, 1'b1, 1'b1))
						: (last_cur && pre_stall(cur_sel, 1'b0, 1'b1))) begin // [R10]
						st_next = mhpa_pkg::ST_PRE;
					end else begin
						st_next = mhpa_pkg::ST_ACT; // [R14] [R20]
						do_read = cur_rd && first_cur;
					end
				end
			end
			mhpa_pkg::ST_PRE: begin
				// Stall abandoned when chip select drops
				if (!cs_act) begin
					st_next = mhpa_pkg::ST_IDLE; // [R08]
				end else if (!pre_stall(acc_sel_reg, acc_rd_reg, 1'b0)) begin
					if (acc_rd_reg && acc_sel_reg == mhpa_pkg::SEL_DATA_FIX) begin
						push    = 1'b1;
						st_next = mhpa_pkg::ST_RET;
					end else begin
						st_next = mhpa_pkg::ST_ACT;
						do_read = acc_rd_reg;
					end
				end
			end
			mhpa_pkg::ST_RET: begin
				if (read_return_valid) begin
					rdata_next   = read_return_data;
					post_rd_next = 1'b0;
					st_next      = mhpa_pkg::ST_ACT;
				end
			end
			mhpa_pkg::ST_ACT: begin
				if (strb_rise) begin
					st_next = mhpa_pkg::ST_IDLE;
					if (!acc_rd_reg && !last_acc) begin
						lo_data_next = p_data[mhpa_pkg::HALF_W-1:0]; // [R04]
						lo_be_next   = ~p_be_n[mhpa_pkg::HALF_BE_W-1:0]; // [R06]
					end else if (!acc_rd_reg) begin
						push       = 1'b1;
						push_entry = {1'b0, acc_sel_reg, be_full, data_full}; // [R04]
						addr_set   = (acc_sel_reg == mhpa_pkg::SEL_ADDR);
						if (wr_post)
							st_next = mhpa_pkg::ST_POST; // [R09]
					end else if (last_acc && acc_sel_reg == mhpa_pkg::SEL_DATA_INC
						&& post_rd_reg) begin
						st_next = mhpa_pkg::ST_POST; // [R22]
					end
				end
			end
			mhpa_pkg::ST_POST: begin
				if (!cs_act)
					st_next = mhpa_pkg::ST_IDLE; // [R09]
			end
			default: st_next = mhpa_pkg::ST_IDLE;
		endcase
		// Starting a read fetches the word once, on its first halfword
		if (do_read) begin
			case (rsel)
				mhpa_pkg::SEL_CTRL: rdata_next = control_reg_value;
				mhpa_pkg::SEL_ADDR: rdata_next = address_reg_value;
				mhpa_pkg::SEL_DATA_INC: begin
					rdata_next   = read_fifo_head;
					post_rd_next = read_fifo_one_left; // [R22]
					push         = 1'b1;
				end
				default: rdata_next = rdata_reg;
			endcase
		end
		// A new address write wins over the drain of the previous one
		addr_pend_next = (addr_pend_reg && !addr_drain) || addr_set; // [R15]
		out_next = dual_halfword_mode ? {mhpa_pkg::HALF_ZERO, acc_hw_reg
			? rdata_reg[mhpa_pkg::WORD_W-1:mhpa_pkg::HALF_W]
			: rdata_reg[mhpa_pkg::HALF_W-1:0]} : rdata_reg;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg        <= mhpa_pkg::ST_IDLE;
			acc_sel_reg   <= mhpa_pkg::SEL_CTRL;
			acc_rd_reg    <= 1'b1;
			acc_hw_reg    <= 1'b0;
			lo_data_reg   <= mhpa_pkg::HALF_ZERO;
			lo_be_reg     <= 2'h0;
			rdata_reg     <= mhpa_pkg::WORD_ZERO;
			out_reg       <= mhpa_pkg::WORD_ZERO;
			post_rd_reg   <= 1'b0;
			addr_pend_reg <= 1'b0;
		end else begin
			st_reg        <= st_next;
			acc_sel_reg   <= acc_sel_next;
			acc_rd_reg    <= acc_rd_next;
			acc_hw_reg    <= acc_hw_next;
			lo_data_reg   <= lo_data_next;
			lo_be_reg     <= lo_be_next;
			rdata_reg     <= rdata_next;
			out_reg       <= out_next;
			post_rd_reg   <= post_rd_next;
			addr_pend_reg <= addr_pend_next;
		end
	end
	// Not-ready only shows while chip select is held
	assign host_ready_out = !(cs_act && (st_reg == mhpa_pkg::ST_PRE
		|| st_reg == mhpa_pkg::ST_RET || st_reg == mhpa_pkg::ST_POST)); // [R08]
	// Bus driven for the host to sample on the strobe rise
	assign host_data_bus_oe  = cs_act && strb && acc_rd_reg
		&& st_reg == mhpa_pkg::ST_ACT; // [R12]
	assign host_data_bus_out = out_reg;
	sequence s_start_rd(logic [1:0] s);
		strb_fall && st_reg == mhpa_pkg::ST_IDLE && cur_rd && first_cur && cur_sel == s;
	endsequence
	sequence s_wr_done;
		strb_rise && st_reg == mhpa_pkg::ST_ACT && !acc_rd_reg && last_acc;
	endsequence
	// An ungated strobe would start an access with chip select off
	a_strobe_gated: assert property ((!cs_act && st_reg == mhpa_pkg::ST_IDLE) // [R23]
		|=> st_reg == mhpa_pkg::ST_IDLE)
		else $error("access started without chip select");
	a_ready_cs_free: assert property (!cs_act |-> host_ready_out) // [R08]
		else $error("ready low without chip select");
	a_post_holds: assert property ((st_reg == mhpa_pkg::ST_POST && cs_act) // [R09]
		|=> st_reg == mhpa_pkg::ST_POST || !cs_act)
		else $error("post stall left while chip select held");
	a_fix_wr_post: assert property ((s_wr_done // [R16] [R18]
		and acc_sel_reg == mhpa_pkg::SEL_DATA_FIX) |=> st_reg == mhpa_pkg::ST_POST)
		else $error("fixed data write without post stall");
	a_wr_pushed: assert property (s_wr_done |=> req_valid) // [R04]
		else $error("completed write not queued");
	a_fix_rd_stall: assert property (s_start_rd(mhpa_pkg::SEL_DATA_FIX) // [R21]
		|=> st_reg == mhpa_pkg::ST_PRE)
		else $error("fixed data read did not stall");
	a_ctrl_rd_ready: assert property (s_start_rd(mhpa_pkg::SEL_CTRL) // [R20]
		|=> st_reg == mhpa_pkg::ST_ACT ##1 host_ready_out)
		else $error("control read stalled");
	a_read_no_be: assert property ((req_valid && req_read) // [R11]
		|-> req_byte_enables == mhpa_pkg::BE_NONE)
		else $error("read request carries byte enables");
	a_first_half_ok: assert property ((strb_fall && st_reg == mhpa_pkg::ST_IDLE // [R10]
		&& dual_halfword_mode && !cur_rd && !cur_hw) |=> st_reg == mhpa_pkg::ST_ACT)
		else $error("first write halfword stalled");
	a_addr_pend_stall: assert property ((strb_fall && st_reg == mhpa_pkg::ST_IDLE // [R15]
		&& !cur_rd && last_cur && cur_sel == mhpa_pkg::SEL_ADDR && addr_pend_reg)
		|=> !host_ready_out || !cs_act)
		else $error("address write not stalled while pending");
endmodule : mhpa_port

`default_nettype wire

/* File: shared/mhpa_pkg.sv */
// Functional notes
// R01: Select picks control, address, or data register
// R02: No address strobe: capture on strobe fall
// R03: Address strobe used: capture on its fall
// R04: Write data and enables captured on rise
// R05: Host gives all enables except fixed data
// R06: Dual halfword: two enables per halfword
// R07: Halfword identifier captured with the select
// R08: Initial not-ready shown only under chip select
// R09: Post not-ready held until chip select drops
// R10: Dual write stalls only on second halfword
// R11: Byte enables ignored during reads
// R12: Host samples read data on strobe rise
// R13: Host may drop address strobe after capture
// R14: Ready kept for ordinary writes
// R15: Stall on pending address or full FIFO
// R16: Fixed write, FIFO busy: stall then post
// R17: Increment write, FIFO stays full: both stalls
// R18: Fixed write, FIFO empty: post stall only
// R19: Write filling FIFO: post stall only
// R20: No stall for control, address, buffered reads
// R21: Stall fixed reads and reads of empty FIFO
// R22: Read emptying FIFO stalls after completion
// R23: Internal strobe gated by chip select
`default_nettype none

package mhpa_pkg;

	// Register select codes
	localparam logic [1:0] SEL_CTRL     = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_ADDR     = 2'h2;
	localparam logic [1:0] SEL_DATA_FIX = 2'h3;

	// Widths of the host word and its halves
	localparam int WORD_W    = 32;
	localparam int HALF_W    = 16;
	localparam int BE_W      = 4;
	localparam int HALF_BE_W = 2;
	localparam int BUF_DEPTH = 2;
	localparam int SYNC_W    = 1 + 2 + 1 + 2 + 1 + 1 + BE_W + WORD_W;

	// Reset values
	localparam logic [BE_W-1:0]   BE_NONE   = 4'h0;
	localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0;
	localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0;
	localparam logic [SYNC_W-1:0] PIN_IDLE  = {SYNC_W{1'b1}};

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_RET,
		ST_ACT,
		ST_POST
	} mhpa_state_t;

endpackage : mhpa_pkg

`default_nettype wire
